// File: combiner_params.svh
`ifndef COMBINER_PARAMS_SVH
`define COMBINER_PARAMS_SVH
// Summary of operation
// - The tree has 128 channel oscillators, 16 octave oscillators, four block oscillators and one global oscillator.
// - Each channel passes five gain stages and its frequency is the sum of the channel, octave and block oscillators on its path.
// - Control words are 19, 21, 20 and 21 bits wide for channel, octave, block and global oscillators.
// - Channel and octave steps are rate over 2^25, block and global steps rate over 2^2, with the printed ranges.
// - The first channel gain is 11 bits, the other four gains are 8 bits, all unsigned magnitudes.
// - A channel whose two channel gains are both zero contributes nothing to the output.
// - The output carries one sample per clock, repeated in both halves of the pair.
// - The first two gains scale one channel, the third gain scales its eight-channel combiner.
// - All oscillator and gain words arrive over the serial configuration port.
`define CH_COUNT        128
`define OCT_COUNT       16
`define BLK_COUNT       4
`define CH_FCW_W        19
`define OCT_FCW_W       21
`define BLK_FCW_W       20
`define GLB_FCW_W       21
`define GAIN_A_W        11
`define GAIN_B_W        8
`define PHASE_W         25
`define CH_STEP_SHIFT   0
`define OCT_STEP_SHIFT  0
`define BLK_STEP_SHIFT  23
`define GLB_STEP_SHIFT  23
`define CFG_ADDR_W      16
`define SEL_CH_OSC      4'h0
`define SEL_OCT_OSC     4'h1
`define SEL_BLK_OSC     4'h2
`define SEL_GLB_OSC     4'h3
`define SEL_GAIN_A      4'h4
`define SEL_GAIN_B      4'h5
`define SEL_GAIN_OCT    4'h6
`define SEL_GAIN_FOUR   4'h7
`define SEL_GAIN_FIVE   4'h8
`define GAIN_RESET_A    11'h000
`define GAIN_RESET_B    8'h00
`define GAIN_RESET_C    8'h00
`define SPI_FRAME_BITS  6'h28
`endif

// File: combiner_pkg.sv
package combiner_pkg;
  typedef struct packed {
    logic [3:0]  sel;
    logic [11:0] index;
    logic [23:0] data;
  } cfg_word_s;
  typedef struct packed {
    logic [15:0] even;
    logic [15:0] odd;
  } sample_pair_s;
  typedef enum logic [2:0] {
    SPI_IDLE  = 3'b001,
    SPI_SHIFT = 3'b010,
    SPI_DONE  = 3'b100
  } spi_state_e;
endpackage

// File: sample_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic [WIDTH-1:0]      rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two.");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wp_reg;
  logic [AW:0]      wp_next;
  logic [AW:0]      rp_reg;
  logic [AW:0]      rp_next;
  logic             push;
  logic             pop;
  always_comb begin
    wr_ready_out = (wp_reg - rp_reg) != (AW+1)'(DEPTH);
    rd_valid_out = wp_reg != rp_reg;
    rd_data_out  = mem_reg[rp_reg[AW-1:0]];
    push         = wr_valid_in && wr_ready_out;
    pop          = rd_valid_out && rd_ready_in;
    wp_next      = wp_reg + (AW+1)'(push);
    rp_next      = rp_reg + (AW+1)'(pop);
  end
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
    end
  end
  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem_reg[wp_reg[AW-1:0]] <= wr_data_in;
    end
  end
endmodule
`default_nettype wire

// File: gain_stage.sv
`timescale 1ns/1ps
`default_nettype none
module gain_stage #(
  parameter int DW = 16,
  parameter int GW = 8
) (
  input  wire logic signed [DW-1:0] sample_in,
  input  wire logic        [GW-1:0] gain_in,
  output logic signed [DW-1:0]      sample_out
);
  logic signed [DW+GW:0] prod;
  always_comb begin
    // Unsigned gain with the top bit as unity, so full scale is kept.
    prod       = sample_in * $signed({1'b0, gain_in});
    sample_out = prod[DW+GW-2 -: DW];
  end
endmodule
`default_nettype wire

// File: channel_combiner.sv
`timescale 1ns/1ps
`default_nettype none
`include "combiner_params.svh"
module channel_combiner #(
  parameter int NCH = `CH_COUNT,
  parameter int DW  = 16
) (
  input  wire logic                          mclk_in,
  input  wire logic                          rst_n_in,
  input  wire logic                          spi_csn_in,
  input  wire logic                          spi_sclk_in,
  input  wire logic                          spi_mosi_in,
  input  wire logic [NCH-1:0][DW-1:0]        ch_sample_in,
  input  wire logic                          ch_valid_in,
  output logic                               ch_ready_out,
  output combiner_pkg::sample_pair_s         dac_pair_out,
  output logic                               dac_valid_out,
  input  wire logic                          dac_ready_in,
  output logic [`GLB_FCW_W-1:0]              global_fcw_out
);
  initial begin
    if (NCH < 8 || NCH > `CH_COUNT || NCH % 8 != 0) $error("NCH must be a multiple of 8 up to 128.");
  end
  localparam int NOCT = NCH / 8;
  // ==========================================================
  // Serial configuration port
  // ==========================================================
  combiner_pkg::spi_state_e spi_state_reg;
  combiner_pkg::spi_state_e spi_state_next;
  logic [39:0]              shift_reg;
  logic [39:0]              shift_next;
  logic [5:0]               bits_reg;
  logic [5:0]               bits_next;
  logic                     sclk_d_reg;
  logic                     wr_stb;
  combiner_pkg::cfg_word_s  cfg;
  always_comb begin
    spi_state_next = spi_state_reg;
    shift_next     = shift_reg;
    bits_next      = bits_reg;
    wr_stb         = 1'b0;
    cfg            = shift_reg;
    case (spi_state_reg)
      combiner_pkg::SPI_IDLE: begin
        bits_next = '0;
        if (!spi_csn_in) begin
          spi_state_next = combiner_pkg::SPI_SHIFT;
        end
      end
      combiner_pkg::SPI_SHIFT: begin
        if (spi_csn_in) begin
          spi_state_next = combiner_pkg::SPI_IDLE;
        end else if (spi_sclk_in && !sclk_d_reg) begin
          shift_next = {shift_reg[38:0], spi_mosi_in};
          bits_next  = bits_reg + 6'h01;
          if (bits_reg == `SPI_FRAME_BITS - 6'h01) begin
            spi_state_next = combiner_pkg::SPI_DONE;
          end
        end
      end
      combiner_pkg::SPI_DONE: begin
        wr_stb         = 1'b1;
        spi_state_next = spi_csn_in ? combiner_pkg::SPI_IDLE : combiner_pkg::SPI_SHIFT;
        bits_next      = '0;
      end
      default: begin
        spi_state_next = combiner_pkg::SPI_IDLE;
      end
    endcase
  end
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      spi_state_reg <= combiner_pkg::SPI_IDLE;
      shift_reg     <= '0;
      bits_reg      <= '0;
      sclk_d_reg    <= 1'b0;
    end else begin
      spi_state_reg <= spi_state_next;
      shift_reg     <= shift_next;
      bits_reg      <= bits_next;
      sclk_d_reg    <= spi_sclk_in;
    end
  end
  // ==========================================================
  // Configuration storage
  // ==========================================================
  // Oscillator words stay in sign and magnitude form as written.
  logic [NCH-1:0][`CH_FCW_W-1:0]  ch_fcw_reg;
  logic [NOCT-1:0][`OCT_FCW_W-1:0] oct_fcw_reg;
  logic [3:0][`BLK_FCW_W-1:0]      blk_fcw_reg;
  logic [`GLB_FCW_W-1:0]           glb_fcw_reg;
  logic [NCH-1:0][`GAIN_A_W-1:0]   gain_a_reg;
  logic [NCH-1:0][`GAIN_B_W-1:0]   gain_b_reg;
  logic [NOCT-1:0][`GAIN_B_W-1:0]  gain_oct_reg;
  logic [`GAIN_B_W-1:0]            gain_four_reg;
  logic [`GAIN_B_W-1:0]            gain_five_reg;
  logic [NCH-1:0][`PHASE_W-1:0]    ch_ph_reg;
  logic [NCH-1:0][`PHASE_W-1:0]    ch_ph_next;
  logic [`PHASE_W-1:0]             glb_ph_reg;
  logic [`PHASE_W-1:0]             glb_ph_next;
  function automatic logic [`PHASE_W-1:0] sm_step(input logic [23:0] w, input int wd,
                                                 input int sh);
    logic [`PHASE_W-1:0] mag;
    // Widened before the shift so the coarse steps keep both low magnitude bits.
    mag = `PHASE_W'(w & ((24'h000001 << (wd - 1)) - 24'h000001)) << sh;
    return w[wd-1] ? -mag : mag;
  endfunction
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ch_fcw_reg    <= '0;
      oct_fcw_reg   <= '0;
      blk_fcw_reg   <= '0;
      glb_fcw_reg   <= '0;
      gain_a_reg    <= {NCH{`GAIN_RESET_A}};
      gain_b_reg    <= {NCH{`GAIN_RESET_B}};
      gain_oct_reg  <= {NOCT{`GAIN_RESET_C}};
      gain_four_reg <= `GAIN_RESET_C;
      gain_five_reg <= `GAIN_RESET_C;
    end else if (wr_stb) begin
      case (cfg.sel)
        // The modulus is kept at the index width so a full count never folds to zero.
        `SEL_CH_OSC:    ch_fcw_reg[cfg.index % 12'(NCH)] <= cfg.data[`CH_FCW_W-1:0];
        `SEL_OCT_OSC:   oct_fcw_reg[cfg.index % 12'(NOCT)] <= cfg.data[`OCT_FCW_W-1:0];
        `SEL_BLK_OSC:   blk_fcw_reg[cfg.index[1:0]] <= cfg.data[`BLK_FCW_W-1:0];
        `SEL_GLB_OSC:   glb_fcw_reg <= cfg.data[`GLB_FCW_W-1:0];
        `SEL_GAIN_A:    gain_a_reg[cfg.index % 12'(NCH)] <= cfg.data[`GAIN_A_W-1:0];
        `SEL_GAIN_B:    gain_b_reg[cfg.index % 12'(NCH)] <= cfg.data[`GAIN_B_W-1:0];
        `SEL_GAIN_OCT:  gain_oct_reg[cfg.index % 12'(NOCT)] <= cfg.data[`GAIN_B_W-1:0];
        `SEL_GAIN_FOUR: gain_four_reg <= cfg.data[`GAIN_B_W-1:0];
        `SEL_GAIN_FIVE: gain_five_reg <= cfg.data[`GAIN_B_W-1:0];
        default: begin
        end
      endcase
    end
  end
  // ==========================================================
  // Oscillator phase accumulators and gain datapath
  // ==========================================================
  logic                             advance;
  logic [NCH-1:0][DW-1:0]           ch_scaled;
  logic [NOCT-1:0][DW+3:0]          oct_sum;
  logic [NOCT-1:0][DW-1:0]          oct_scaled;
  logic signed [DW+7:0]             tree_sum;
  logic [DW-1:0]                    out_a;
  logic [DW-1:0]                    out_b;
  logic [31:0]                      fifo_din;
  logic                             fifo_ready;
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic [DW-1:0] s1;
      logic [DW-1:0] s2;
      gain_stage #(.DW(DW), .GW(`GAIN_A_W)) u_ga (
        .sample_in  (ch_sample_in[g]),
        .gain_in    (gain_a_reg[g]),
        .sample_out (s1)
      );
      // Both channel gains at zero silence the channel entirely.
      gain_stage #(.DW(DW), .GW(`GAIN_B_W)) u_gb (
        .sample_in  (s1),
        .gain_in    (gain_b_reg[g]),
        .sample_out (s2)
      );
      assign ch_scaled[g] = s2;
      // Path frequency sums the channel, octave and block steps; the global step has its own accumulator.
      assign ch_ph_next[g] = ch_ph_reg[g]
        + sm_step(24'(ch_fcw_reg[g]), `CH_FCW_W, `CH_STEP_SHIFT)
        + sm_step(24'(oct_fcw_reg[g/8]), `OCT_FCW_W, `OCT_STEP_SHIFT)
        + sm_step(24'(blk_fcw_reg[g/32]), `BLK_FCW_W, `BLK_STEP_SHIFT);
    end
    for (g = 0; g < NOCT; g++) begin : g_oct
      always_comb begin
        oct_sum[g] = '0;
        for (int k = 0; k < 8; k++) begin
          oct_sum[g] = oct_sum[g] + (DW+4)'(signed'(ch_scaled[g*8+k]));
        end
      end
      gain_stage #(.DW(DW), .GW(`GAIN_B_W)) u_go (
        .sample_in  (oct_sum[g][DW+2:3]),
        .gain_in    (gain_oct_reg[g]),
        .sample_out (oct_scaled[g])
      );
    end
  endgenerate
  always_comb begin
    tree_sum = '0;
    for (int k = 0; k < NOCT; k++) begin
      tree_sum = tree_sum + (DW+8)'(signed'(oct_scaled[k]));
    end
  end
  gain_stage #(.DW(DW), .GW(`GAIN_B_W)) u_g4 (
    .sample_in  (tree_sum[DW+3:4]),
    .gain_in    (gain_four_reg),
    .sample_out (out_a)
  );
  gain_stage #(.DW(DW), .GW(`GAIN_B_W)) u_g5 (
    .sample_in  (out_a),
    .gain_in    (gain_five_reg),
    .sample_out (out_b)
  );
  // Second sample of the pair is the same value, written in the same clock.
  assign fifo_din     = {out_b, out_b};
  assign advance      = ch_valid_in && fifo_ready;
  assign glb_ph_next  = glb_ph_reg + sm_step(24'(glb_fcw_reg), `GLB_FCW_W, `GLB_STEP_SHIFT);
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ch_ph_reg    <= '0;
      glb_ph_reg   <= '0;
      ch_ready_out <= 1'b0;
    end else begin
      ch_ready_out <= fifo_ready;
      if (advance) begin
        ch_ph_reg  <= ch_ph_next;
        glb_ph_reg <= glb_ph_next;
      end
    end
  end
  combiner_pkg::sample_pair_s fifo_q;
  logic                       fifo_v;
  sample_fifo #(.WIDTH(32), .DEPTH(8)) u_fifo (
    .mclk_in      (mclk_in),
    .rst_n_in     (rst_n_in),
    .wr_data_in   (fifo_din),
    .wr_valid_in  (ch_valid_in),
    .wr_ready_out (fifo_ready),
    .rd_data_out  (fifo_q),
    .rd_valid_out (fifo_v),
    .rd_ready_in  (!dac_valid_out || dac_ready_in)
  );
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dac_pair_out   <= '0;
      dac_valid_out  <= 1'b0;
      global_fcw_out <= '0;
    end else begin
      global_fcw_out <= glb_fcw_reg;
      if (!dac_valid_out || dac_ready_in) begin
        dac_valid_out <= fifo_v;
        // Only a real beat is loaded, so an empty buffer never shows unwritten storage.
        if (fifo_v) begin
          dac_pair_out <= fifo_q;
        end
      end
    end
  end
  // ==========================================================
  // Checks
  // ==========================================================
  a_spi_frame_len: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    spi_state_reg == combiner_pkg::SPI_DONE |-> $past(bits_reg) == 6'h27)
    else $error("Frame accepted with wrong bit count.");
  a_muted_channel: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    gain_a_reg[0] == '0 && gain_b_reg[0] == '0 |-> ch_scaled[0] == '0)
    else $error("Muted channel still contributes.");
  a_glb_word_held: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    1'b1 |=> global_fcw_out == $past(glb_fcw_reg))
    else $error("Global word not presented.");
  a_pair_equal: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    dac_valid_out |-> dac_pair_out.even == dac_pair_out.odd)
    else $error("Sample pair mismatch.");
  a_phase_hold: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !advance |=> $stable(glb_ph_reg))
    else $error("Phase moved without a sample.");
  a_gain_write: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    wr_stb && cfg.sel == `SEL_GAIN_FOUR |=> gain_four_reg == $past(cfg.data[7:0]))
    else $error("Gain word not stored.");
  a_zero_gain_stage: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    gain_five_reg == '0 |-> out_b == '0)
    else $error("Zero gain passes signal.");
  a_osc_sign: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    glb_fcw_reg[`GLB_FCW_W-2:0] == '0 && advance |=> glb_ph_reg == $past(glb_ph_reg))
    else $error("Zero magnitude moved phase.");
endmodule
`default_nettype wire

// File: host_spi_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host side of the serial configuration port
// ==========================================================
module host_spi_model (
  input  wire logic mclk_in,
  output logic      spi_csn_out,
  output logic      spi_sclk_out,
  output logic      spi_mosi_out
);
  // Each serial clock level lasts three system clocks, above the one the port needs.
  localparam int HALF = 3;

  initial begin
    spi_csn_out  = 1'b1;
    spi_sclk_out = 1'b0;
    spi_mosi_out = 1'b0;
  end

  // Sends the first nbits of the word, most significant first; fewer than 40 aborts it.
  // The serial clock stands low outside frames and the released data line is inverted.
  task automatic send_frame(input logic [39:0] word, input int nbits);
    int i;
    @(posedge mclk_in);
    spi_csn_out <= 1'b0;
    for (i = 0; i < nbits; i++) begin
      spi_mosi_out <= word[39-i];
      repeat (HALF) @(posedge mclk_in);
      spi_sclk_out <= 1'b1;
      repeat (HALF) @(posedge mclk_in);
      spi_sclk_out <= 1'b0;
    end
    repeat (HALF) @(posedge mclk_in);
    spi_csn_out  <= 1'b1;
    spi_mosi_out <= ~spi_mosi_out;
  endtask
endmodule
`default_nettype wire

// File: channel_combiner_nco_gain_config_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "combiner_params.svh"
module channel_combiner_nco_gain_config_bench;
  localparam int NCH = `CH_COUNT;

  typedef struct packed {
    logic [39:0] frame;
    logic [20:0] exp;
  } row_s;

  logic                      mclk_in;
  logic                      rst_n_in;
  logic                      spi_csn;
  logic                      spi_sclk;
  logic                      spi_mosi;
  logic [NCH-1:0][15:0]      ch_sample_in;
  logic                      ch_valid_in;
  logic                      ch_ready_out;
  combiner_pkg::sample_pair_s dac_pair_out;
  logic                      dac_valid_out;
  logic                      dac_ready_in;
  logic [`GLB_FCW_W-1:0]     global_fcw_out;
  int                        fails;
  int                        compares;
  row_s                      rows [0:4];
  logic [39:0]               gains [0:5];
  logic                      nz;
  logic                      seen;

  host_spi_model i_host_spi_model (
    .mclk_in      (mclk_in),
    .spi_csn_out  (spi_csn),
    .spi_sclk_out (spi_sclk),
    .spi_mosi_out (spi_mosi)
  );

  channel_combiner #(.NCH(NCH), .DW(16)) i_channel_combiner (
    .mclk_in        (mclk_in),
    .rst_n_in       (rst_n_in),
    .spi_csn_in     (spi_csn),
    .spi_sclk_in    (spi_sclk),
    .spi_mosi_in    (spi_mosi),
    .ch_sample_in   (ch_sample_in),
    .ch_valid_in    (ch_valid_in),
    .ch_ready_out   (ch_ready_out),
    .dac_pair_out   (dac_pair_out),
    .dac_valid_out  (dac_valid_out),
    .dac_ready_in   (dac_ready_in),
    .global_fcw_out (global_fcw_out)
  );

  // ==========================================================
  // Clock, watchdog and shared tasks
  // ==========================================================
  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end

  // About a dozen frames of 250 cycles plus sample windows fit well inside this span.
  initial begin
    repeat (40000) @(posedge mclk_in);
    fails++;
    finish_test();
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic send(input logic [39:0] frame, input int nbits);
    i_host_spi_model.send_frame(frame, nbits);
    repeat (4) @(posedge mclk_in);
  endtask

  // Watches the output stream; both halves of a pair must agree on every beat.
  task automatic watch(input int n, output logic any_nz, output logic any_seen);
    int k;
    any_nz = 1'b0;
    any_seen = 1'b0;
    for (k = 0; k < n; k++) begin
      @(negedge mclk_in);
      if (dac_valid_out === 1'b1) begin
        any_seen = 1'b1;
        if (dac_pair_out.even !== 16'h0000) any_nz = 1'b1;
        check({16'h0000, dac_pair_out.odd}, {16'h0000, dac_pair_out.even});
      end
    end
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    rst_n_in = 1'b0;
    ch_sample_in = '0;
    ch_valid_in = 1'b0;
    dac_ready_in = 1'b1;
    fails = 0;
    compares = 0;
    rows[0] = '{{`SEL_GLB_OSC, 12'h000, 24'h000001}, 21'h000001};
    rows[1] = '{{`SEL_GLB_OSC, 12'h000, 24'h1fffff}, 21'h1fffff};
    rows[2] = '{{`SEL_GLB_OSC, 12'h000, 24'h100000}, 21'h100000};
    rows[3] = '{{4'hf, 12'h000, 24'h0aaaaa}, 21'h100000};
    rows[4] = '{{`SEL_GLB_OSC, 12'h005, 24'h0a5a5a}, 21'h0a5a5a};
    gains[0] = {`SEL_CH_OSC, 12'h000, 24'h03ffff};
    gains[1] = {`SEL_GAIN_A, 12'h000, 24'h00028a};
    gains[2] = {`SEL_GAIN_B, 12'h000, 24'h0000fe};
    gains[3] = {`SEL_GAIN_OCT, 12'h000, 24'h0000fe};
    gains[4] = {`SEL_GAIN_FOUR, 12'h000, 24'h0000fe};
    gains[5] = {`SEL_GAIN_FIVE, 12'h000, 24'h0000fe};
    repeat (12) @(posedge mclk_in);
    @(negedge mclk_in);
    check({11'h000, global_fcw_out}, 32'h00000000);
    check({31'h0, dac_valid_out}, 32'h00000000);
    @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    for (int i = 0; i < 5; i++) begin
      send(rows[i].frame, 40);
      check({11'h000, global_fcw_out}, {11'h000, rows[i].exp});
    end
    send({`SEL_GLB_OSC, 12'h000, 24'h012345}, 20);
    check({11'h000, global_fcw_out}, 32'h000a5a5a);
    @(posedge mclk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    check({11'h000, global_fcw_out}, 32'h00000000);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    ch_sample_in <= {NCH{16'h2000}};
    ch_valid_in <= 1'b1;
    watch(200, nz, seen);
    check({30'h0, seen, nz}, 32'h00000002);
    // Gains set last, as a host brings a channel up only once its tuning is loaded.
    for (int i = 0; i < 6; i++) send(gains[i], 40);
    watch(300, nz, seen);
    check({30'h0, seen, nz}, 32'h00000003);
    send({`SEL_GAIN_A, 12'h000, 24'h000000}, 40);
    send({`SEL_GAIN_B, 12'h000, 24'h000000}, 40);
    repeat (20) @(posedge mclk_in);
    watch(200, nz, seen);
    check({30'h0, seen, nz}, 32'h00000002);
    @(posedge mclk_in);
    dac_ready_in <= 1'b0;
    for (int k = 0; k < 60 && ch_ready_out !== 1'b0; k++) @(negedge mclk_in);
    check({31'h0, ch_ready_out}, 32'h00000000);
    @(posedge mclk_in);
    ch_valid_in <= 1'b0;
    dac_ready_in <= 1'b1;
    for (int k = 0; k < 60 && dac_valid_out !== 1'b0; k++) @(negedge mclk_in);
    check({31'h0, dac_valid_out}, 32'h00000000);
    finish_test();
  end
endmodule
`default_nettype wire
